// >>> bench/afs_apdu_session_monitor.sv
`timescale 1ns/10ps
module afs_apdu_session_monitor #(
  parameter FSD_BYTES = 64
) (
  input wire        clk_sys_in,
  input wire        rstn_in,
  input wire        frame_end_in,
  input wire        frame_chain_in,
  input wire        clock_gated_in,
  input wire        auth_fail_in,
  input wire        halt_in,
  input wire        link_clk_in,
  input wire [7:0]  rd_byte_out,
  input wire        cmd_valid_out,
  input wire [1:0]  cmd_kind_out,
  input wire        write_commit_out,
  input wire        write_stream_out,
  input wire        status_valid_out,
  input wire [1:0]  session_state_out,
  input wire [4:0]  session_key_ref_out,
  input wire        sm_active_out,
  input wire        link_edge_out,
  input wire [15:0] resp_chunk_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  // ************************************************************
  // checks
  // ************************************************************
  a_status_after_end: assert property (frame_end_in && !frame_chain_in |=> status_valid_out)
    else $error("status word missing after final frame end");
  a_status_cause: assert property (status_valid_out |-> $past(frame_end_in) && !$past(frame_chain_in))
    else $error("status word without a final frame end");
  a_gated_ones: assert property (clock_gated_in && $past(clock_gated_in) |-> rd_byte_out == 8'hFF)
    else $error("read byte not all ones while gated");
  a_cmd_kind_known: assert property (cmd_valid_out |-> cmd_kind_out == 2'h1 || cmd_kind_out == 2'h2)
    else $error("command issued with no kind");
  a_halt_closes: assert property (halt_in && $past(halt_in) |-> session_state_out == 2'h0 && !sm_active_out)
    else $error("session open during halt");
  a_unauth_no_key: assert property (session_state_out == 2'h0 && $past(session_state_out) == 2'h0
                                    |-> !sm_active_out && !session_key_ref_out[4])
    else $error("key or messaging live while unauthenticated");
  a_fail_drops: assert property (auth_fail_in |-> ##[1:2] session_state_out == 2'h0)
    else $error("auth failure left session state");
  a_chunk_fits: assert property (resp_chunk_out <= FSD_BYTES)
    else $error("response piece larger than host frame");
  a_commit_alone: assert property (write_commit_out |-> !write_stream_out)
    else $error("atomic commit during streamed write");
  a_link_edge_seen: assert property ($rose(link_clk_in) |-> ##[1:4] link_edge_out)
    else $error("link edge not reported");
endmodule
bind afs_apdu_session afs_apdu_session_monitor #(.FSD_BYTES(FSD_BYTES)) i_afs_apdu_session_monitor (
  .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .frame_end_in(frame_end_in), .frame_chain_in(frame_chain_in),
  .clock_gated_in(clock_gated_in), .auth_fail_in(auth_fail_in), .halt_in(halt_in), .link_clk_in(link_clk_in),
  .rd_byte_out(rd_byte_out), .cmd_valid_out(cmd_valid_out), .cmd_kind_out(cmd_kind_out),
  .write_commit_out(write_commit_out), .write_stream_out(write_stream_out),
  .status_valid_out(status_valid_out), .session_state_out(session_state_out),
  .session_key_ref_out(session_key_ref_out), .sm_active_out(sm_active_out),
  .link_edge_out(link_edge_out), .resp_chunk_out(resp_chunk_out));

// >>> bench/afs_apdu_session_tb.sv
`timescale 1ns/10ps
module afs_apdu_session_tb;
  reg         clk_sys_in, rstn_in, rd_strobe_in, clock_gated_in, auth_ok_in, auth_fail_in, halt_in;
  reg  [3:0]  key_no_in;
  wire        f_start, f_valid, f_end, f_chain, f_iface, link_clk;
  wire [7:0]  f_byte, rd_byte_out, native_cmd_out;
  wire        cmd_valid_out, write_commit_out, write_stream_out, write_byte_valid_out, status_valid_out;
  wire        session_iface_out, sm_active_out, link_edge_out;
  wire [1:0]  cmd_kind_out, session_state_out;
  wire [15:0] p1p2_out, lc_out, status_word_out, resp_chunk_out;
  wire [7:0]  write_byte_out;
  wire [4:0]  session_key_ref_out;
  integer     fails, tests_run, cycles, r, k, edges;
  reg  [15:0] sw;
  reg  [63:0] row_bytes [0:3];
  integer     row_len   [0:3];
  reg  [15:0] row_sw    [0:3];
  reg  [7:0]  waw_exp   [0:5];

  afs_host_model i_afs_host_model (.clk_sys_in(clk_sys_in), .frame_start_out(f_start),
    .frame_byte_valid_out(f_valid), .frame_byte_out(f_byte), .frame_end_out(f_end),
    .frame_chain_out(f_chain), .frame_iface_out(f_iface), .link_clk_out(link_clk));
  afs_apdu_session i_afs_apdu_session (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .frame_start_in(f_start),
    .frame_byte_valid_in(f_valid), .frame_byte_in(f_byte), .frame_end_in(f_end), .frame_chain_in(f_chain),
    .frame_iface_in(f_iface), .rd_strobe_in(rd_strobe_in), .clock_gated_in(clock_gated_in),
    .auth_ok_in(auth_ok_in), .auth_fail_in(auth_fail_in), .key_no_in(key_no_in), .halt_in(halt_in),
    .link_clk_in(link_clk), .rd_byte_out(rd_byte_out), .cmd_valid_out(cmd_valid_out),
    .cmd_kind_out(cmd_kind_out), .native_cmd_out(native_cmd_out), .p1p2_out(p1p2_out), .lc_out(lc_out),
    .write_commit_out(write_commit_out), .write_stream_out(write_stream_out), .write_byte_out(write_byte_out),
    .write_byte_valid_out(write_byte_valid_out), .status_word_out(status_word_out),
    .status_valid_out(status_valid_out), .session_state_out(session_state_out),
    .session_iface_out(session_iface_out), .session_key_ref_out(session_key_ref_out),
    .sm_active_out(sm_active_out), .link_edge_out(link_edge_out), .resp_chunk_out(resp_chunk_out));

  always #5 clk_sys_in = ~clk_sys_in;
  // ************************************************************
  // shared tasks
  // ************************************************************
  task check(input [8*12-1:0] what, input [15:0] exp, input [15:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[FAIL] %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  // status stands one cycle, so it is caught in that cycle and not later
  task wait_status;
    begin
      sw = 16'hXXXX;
      for (k = 0; k < 20 && status_valid_out !== 1'b1; k = k + 1) begin
        @(posedge clk_sys_in);
        #1;
      end
      if (status_valid_out === 1'b1) sw = status_word_out;
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk_sys_in);
      #1;
    end
  endtask
  task auth_start;
    begin
      i_afs_host_model.send_apdu({8'h90, 8'h71, 8'h00, 8'h00, 8'h02, 8'h03, 8'h00, 8'h00}, 8, 1'b1);
      wait_status;
      tick(2);
      check("pending", 16'h0001, {14'h0, session_state_out});
      check("native", 16'h0071, {8'h00, native_cmd_out});
    end
  endtask

  always @(posedge clk_sys_in) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      complete_run;
    end
  end

  initial begin
    clk_sys_in = 1'b0; rstn_in = 1'b0; rd_strobe_in = 1'b0; clock_gated_in = 1'b0;
    auth_ok_in = 1'b0; auth_fail_in = 1'b0; halt_in = 1'b0; key_no_in = 4'h0;
    fails = 0; tests_run = 0; cycles = 0; edges = 0;
    row_bytes[0] = {8'h80, 8'hA4, 8'h00, 8'h00, 32'h0}; row_len[0] = 4; row_sw[0] = 16'h6E00;
    row_bytes[1] = {8'h00, 8'hCA, 8'h00, 8'h00, 32'h0}; row_len[1] = 4; row_sw[1] = 16'h6D00;
    row_bytes[2] = {8'h90, 8'hAD, 8'h00, 8'h00, 8'h01, 8'hAA, 8'h05, 8'h00}; row_len[2] = 7; row_sw[2] = 16'h6700;
    row_bytes[3] = {8'h00, 8'hA4, 8'h04, 8'h00, 8'h02, 8'hE1, 8'h04, 8'h00}; row_len[3] = 8; row_sw[3] = 16'h9000;
    waw_exp[0] = 8'hA5; waw_exp[1] = 8'h82; waw_exp[2] = 8'h00;
    waw_exp[3] = 8'h00; waw_exp[4] = 8'h89; waw_exp[5] = 8'hE0;
    tick(8);
    rstn_in = 1'b1;
    check("rd_reset", 16'h00FF, {8'h00, rd_byte_out});
    check("state_reset", 16'h0000, {14'h0, session_state_out});
    check("key_reset", 16'h0000, {11'h0, session_key_ref_out});
    $display("test reset done");
    for (r = 0; r < 4; r = r + 1) begin
      i_afs_host_model.send_apdu(row_bytes[r], row_len[r], 1'b0);
      wait_status;
      check("status", row_sw[r], sw);
    end
    check("p1p2", 16'h0400, p1p2_out);
    check("kind", 16'h0001, {14'h0, cmd_kind_out});
    check("lc", 16'h0002, lc_out);
    check("chunk", 16'h0040, resp_chunk_out);
    $display("test table done");
    tick(2);
    for (r = 0; r < 6; r = r + 1) begin
      check("waw_byte", {8'h00, waw_exp[r]}, {8'h00, rd_byte_out});
      rd_strobe_in = 1'b1;
      tick(1);
      rd_strobe_in = 1'b0;
      tick(1);
    end
    i_afs_host_model.send_apdu({8'h00, 8'hD6, 8'h00, 8'h00, 8'h01, 8'h5A, 16'h0}, 6, 1'b0);
    wait_status;
    check("upd_sw", 16'h9000, sw);
    check("commit", 16'h0001, {15'h0, write_commit_out});
    check("cmd_valid", 16'h0001, {15'h0, cmd_valid_out});
    $display("test write after write done");
    clock_gated_in = 1'b1;
    tick(3);
    check("gated_read", 16'h00FF, {8'h00, rd_byte_out});
    edges = 0;
    for (r = 0; r < 254; r = r + 1) begin
      if (rd_byte_out === 8'hFF) edges = edges + 1;
      rd_strobe_in = 1'b1;
      tick(1);
    end
    rd_strobe_in = 1'b0;
    check("ones_read", 16'd254, edges[15:0]);
    clock_gated_in = 1'b0;
    i_afs_host_model.crc_fail_block;
    $display("test gated read done");
    auth_start;
    key_no_in = 4'h3;
    auth_ok_in = 1'b1;
    tick(1);
    auth_ok_in = 1'b0;
    tick(2);
    check("sym_state", 16'h0002, {14'h0, session_state_out});
    check("key_ref", 16'h0013, {11'h0, session_key_ref_out});
    check("sm_active", 16'h0001, {15'h0, sm_active_out});
    check("owner", 16'h0001, {15'h0, session_iface_out});
    halt_in = 1'b1;
    tick(3);
    halt_in = 1'b0;
    check("halt_close", 16'h0000, {14'h0, session_state_out});
    auth_start;
    auth_fail_in = 1'b1;
    tick(1);
    auth_fail_in = 1'b0;
    tick(2);
    check("fail_state", 16'h0000, {14'h0, session_state_out});
    auth_start;
    i_afs_host_model.send_apdu(row_bytes[3], row_len[3], 1'b1);
    wait_status;
    check("pend_reject", 16'h91AE, sw);
    tick(2);
    check("reject_state", 16'h0000, {14'h0, session_state_out});
    $display("test session done");
    edges = 0;
    fork
      i_afs_host_model.link_burst(10);
      repeat (180) begin
        @(posedge clk_sys_in);
        #1;
        if (link_edge_out === 1'b1) edges = edges + 1;
      end
    join
    check("link_edges", 16'd10, edges[15:0]);
    $display("test link edges done");
    complete_run;
  end
endmodule

// >>> bench/afs_host_model.sv
`timescale 1ns/10ps
module afs_host_model (
  input  wire       clk_sys_in,
  output reg        frame_start_out,
  output reg        frame_byte_valid_out,
  output reg  [7:0] frame_byte_out,
  output reg        frame_end_out,
  output reg        frame_chain_out,
  output reg        frame_iface_out,
  output reg        link_clk_out
);
  initial begin
    frame_start_out      = 1'b0;
    frame_byte_valid_out = 1'b0;
    frame_byte_out       = 8'h00;
    frame_end_out        = 1'b0;
    frame_chain_out      = 1'b0;
    frame_iface_out      = 1'b0;
    link_clk_out         = 1'b0;
  end
  // ************************************************************
  // one apdu frame, bytes left-justified, sent first byte first
  // ************************************************************
  task send_apdu(input [63:0] bytes, input integer n, input iface);
    integer i;
    begin
      @(posedge clk_sys_in);
      #1;
      frame_iface_out = iface;
      frame_start_out = 1'b1;
      for (i = 0; i < n; i = i + 1) begin
        @(posedge clk_sys_in);
        #1;
        frame_start_out      = 1'b0;
        frame_byte_valid_out = 1'b1;
        frame_byte_out       = bytes[63-8*i -: 8];
      end
      @(posedge clk_sys_in);
      #1;
      frame_byte_valid_out = 1'b0;
      // released byte lane flips so a stale value is never mistaken for data
      frame_byte_out       = ~frame_byte_out;
      frame_end_out        = 1'b1;
      @(posedge clk_sys_in);
      #1;
      frame_end_out = 1'b0;
    end
  endtask
  // crc-fail receive-ready block: restarts the frame, carries no apdu
  task crc_fail_block;
    begin
      @(posedge clk_sys_in);
      #1;
      frame_start_out = 1'b1;
      @(posedge clk_sys_in);
      #1;
      frame_start_out = 1'b0;
    end
  endtask
  // link clock runs only inside a burst, odd phase against the system clock
  task link_burst(input integer n);
    integer i;
    begin
      #3;
      for (i = 0; i < n; i = i + 1) begin
        #80 link_clk_out = 1'b1;
        #80 link_clk_out = 1'b0;
      end
    end
  endtask
endmodule

// >>> verilog/afs_apdu_session.v
`timescale 1ns/10ps
`include "afs_regs.vh"
// What this block does
// - second write drops response, returns error frame
// - wrapped native commands and the listed standard commands are executed
// - command code, headers, data; code then data
// - only select, read, update and general authenticate standard commands
// - plain params lsb first, crypto msb first
// - standard command params always msb first
// - header four bytes; lc one or three
// - le zero; wrapped commands require zero le
// - response data up to le, then sw
// - chaining on read/write data and binary
// - long responses split to host frame size
// - oversized chained header gives length error
// - chained frames handled as one frame
// - large writes start before chain ends
// - fitting writes stored atomically or not
// - one session, bound to opening interface
// - listed events close current session
// - reset leaves unauthenticated, key invalid
// - first part accepted enters pending state
// - sym success aes state, asym ecc state
// - gated clock makes reads all ones
// - any auth error returns unauthenticated
module afs_apdu_session #(
  parameter BUF_BYTES = 256,
  parameter FSD_BYTES = 64
) (
  input  wire        clk_sys_in,
  input  wire        rstn_in,
  input  wire        frame_start_in,
  input  wire        frame_byte_valid_in,
  input  wire [7:0]  frame_byte_in,
  input  wire        frame_end_in,
  input  wire        frame_chain_in,
  input  wire        frame_iface_in,
  input  wire        rd_strobe_in,
  input  wire        clock_gated_in,
  input  wire        auth_ok_in,
  input  wire        auth_fail_in,
  input  wire [3:0]  key_no_in,
  input  wire        halt_in,
  input  wire        link_clk_in,
  output wire [7:0]  rd_byte_out,
  output reg         cmd_valid_out,
  output reg  [1:0]  cmd_kind_out,
  output reg  [7:0]  native_cmd_out,
  output reg  [15:0] p1p2_out,
  output reg  [15:0] lc_out,
  output reg         write_commit_out,
  output reg         write_stream_out,
  output reg  [7:0]  write_byte_out,
  output reg         write_byte_valid_out,
  output reg  [15:0] status_word_out,
  output reg         status_valid_out,
  output reg  [1:0]  session_state_out,
  output reg         session_iface_out,
  output reg  [4:0]  session_key_ref_out,
  output reg         sm_active_out,
  output reg         link_edge_out,
  output reg  [15:0] resp_chunk_out
);
  // ************************************************************
  // states and kinds
  // ************************************************************
  localparam [1:0] STATE_UNAUTHENTICATED = 2'd0;
  localparam [1:0] STATE_AUTH_PENDING    = 2'd1;
  localparam [1:0] STATE_AUTH_SYMMETRIC  = 2'd2;
  localparam [1:0] STATE_AUTH_ASYMMETRIC = 2'd3;
  localparam [1:0] KIND_NONE = 2'd0;
  localparam [1:0] KIND_STD  = 2'd1;
  localparam [1:0] KIND_WRAP = 2'd2;
  localparam [2:0] P_CLA = 3'd0;
  localparam [2:0] P_INS = 3'd1;
  localparam [2:0] P_P1  = 3'd2;
  localparam [2:0] P_P2  = 3'd3;
  localparam [2:0] P_LEN = 3'd4;
  localparam [2:0] P_DAT = 3'd5;
  localparam [2:0] P_LE  = 3'd6;
  localparam [15:0] BUF_LIMIT = BUF_BYTES;
  localparam [15:0] FSD_LIMIT = FSD_BYTES;
  // ************************************************************
  // link clock sampling
  // ************************************************************
  // only lclk_s2 feeds logic; s1 may still be settling
  reg lclk_s1;
  reg lclk_s2;
  reg lclk_d;
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lclk_s1       <= 1'b0;
      lclk_s2       <= 1'b0;
      lclk_d        <= 1'b0;
      link_edge_out <= 1'b0;
    end else begin
      lclk_s1       <= link_clk_in;
      lclk_s2       <= lclk_s1;
      lclk_d        <= lclk_s2;
      link_edge_out <= lclk_s2 & ~lclk_d;
    end
  end
  // ************************************************************
  // parser state
  // ************************************************************
  reg  [2:0]  phase;
  reg  [7:0]  cla;
  reg  [7:0]  ins;
  reg  [1:0]  len_idx;
  reg  [15:0] lc_acc;
  reg  [15:0] data_cnt;
  reg  [15:0] total_cnt;
  reg  [7:0]  first_data;
  reg         extended;
  reg  [15:0] le_acc;
  // data-field copy so a fitting write lands all or nothing
  reg  [7:0]  stage [0:BUF_BYTES-1];
  reg         resp_pending;
  reg         waw_active;
  reg         in_chain;
  wire        waw_done;
  wire        is_wrap = (cla == `AFS_CLA_WRAP);
  wire        is_std  = (cla == `AFS_CLA_STD);
  wire        std_ok  = (ins == `AFS_INS_SELECT) || (ins == `AFS_INS_READ_BIN) ||
                        (ins == `AFS_INS_UPDATE_BIN) || (ins == `AFS_INS_GEN_AUTH);
  wire        is_write = (is_wrap && ins == `AFS_CMD_WRITE_DATA) ||
                         (is_std && ins == `AFS_INS_UPDATE_BIN);
  wire        chainable = is_write || (is_wrap && ins == `AFS_CMD_READ_DATA) ||
                          (is_std && ins == `AFS_INS_READ_BIN);
  wire        big_write = is_write && (lc_acc > BUF_LIMIT);
  wire        byte_in   = frame_byte_valid_in && !clock_gated_in;
  wire        native_first = is_wrap && (ins == `AFS_CMD_SYM_FIRST || ins == `AFS_CMD_SYM_NONFRST);
  wire        asym_first   = is_std && ins == `AFS_INS_GEN_AUTH;
  wire        auth_start   = native_first || asym_first;
  wire        second_part  = is_wrap && ins == `AFS_CMD_SYM_PART2;
  afs_resp_mux u_resp_mux (
    .clk_sys_in     (clk_sys_in),
    .rstn_in        (rstn_in),
    .clock_gated_in (clock_gated_in),
    .waw_active_in  (waw_active),
    .rd_strobe_in   (rd_strobe_in),
    .resp_byte_in   (resp_chunk_out[7:0]),
    .rd_byte_out    (rd_byte_out),
    .waw_done_out   (waw_done)
  );
  // ************************************************************
  // apdu byte parser
  // ************************************************************
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      phase      <= P_CLA;
      cla        <= 8'h00;
      ins        <= 8'h00;
      p1p2_out   <= 16'h0000;
      len_idx    <= 2'd0;
      lc_acc     <= 16'h0000;
      le_acc     <= 16'h0000;
      data_cnt   <= 16'h0000;
      total_cnt  <= 16'h0000;
      first_data <= 8'h00;
      extended   <= 1'b0;
      in_chain   <= 1'b0;
      write_stream_out     <= 1'b0;
      write_byte_out       <= 8'h00;
      write_byte_valid_out <= 1'b0;
    end else begin
      write_byte_valid_out <= 1'b0;
      if (frame_start_in && !in_chain) begin
        phase     <= P_CLA;
        len_idx   <= 2'd0;
        lc_acc    <= 16'h0000;
        le_acc    <= 16'h0000;
        data_cnt  <= 16'h0000;
        total_cnt <= 16'h0000;
        extended  <= 1'b0;
        write_stream_out <= 1'b0;
      end else if (byte_in) begin
        total_cnt <= total_cnt + 16'd1;
        case (phase)
          P_CLA: begin
            cla   <= frame_byte_in;
            phase <= P_INS;
          end
          P_INS: begin
            ins   <= frame_byte_in;
            phase <= P_P1;
          end
          P_P1: begin
            p1p2_out[15:8] <= frame_byte_in;
            phase          <= P_P2;
          end
          P_P2: begin
            p1p2_out[7:0] <= frame_byte_in;
            phase         <= P_LEN;
          end
          P_LEN: begin
            // one-byte lc, or 00 then two msb-first bytes
            if (len_idx == 2'd0) begin
              first_data <= frame_byte_in;
              if (frame_byte_in == 8'h00) begin
                extended <= 1'b1;
                len_idx  <= 2'd1;
              end else begin
                lc_acc <= {8'h00, frame_byte_in};
                phase  <= P_DAT;
              end
            end else if (len_idx == 2'd1) begin
              lc_acc[15:8] <= frame_byte_in;
              len_idx      <= 2'd2;
            end else begin
              lc_acc[7:0] <= frame_byte_in;
              phase       <= (lc_acc[15:8] == 8'h00 && frame_byte_in == 8'h00) ? P_LE : P_DAT;
            end
          end
          P_DAT: begin
            if (data_cnt < BUF_LIMIT)
              stage[data_cnt[7:0]] <= frame_byte_in;
            if (big_write) begin
              write_stream_out     <= 1'b1;
              // wire order kept: lsb-first and msb-first fields pass as sent
              write_byte_out       <= frame_byte_in;
              write_byte_valid_out <= 1'b1;
            end
            data_cnt <= data_cnt + 16'd1;
            if (data_cnt + 16'd1 == lc_acc)
              phase <= P_LE;
          end
          // le may be one to three bytes; the last two count
          P_LE: le_acc <= {le_acc[7:0], frame_byte_in};
          default: phase <= P_CLA;
        endcase
      end
      if (frame_end_in)
        in_chain <= frame_chain_in && chainable;
    end
  end
  // ************************************************************
  // dispatch, status word and session machine
  // ************************************************************
  reg       owner_err;
  reg [1:0] kind;
  reg [1:0] next_state;
  always @* begin
    kind = KIND_NONE;
    if (is_wrap)
      kind = KIND_WRAP;
    else if (is_std && std_ok)
      kind = KIND_STD;
  end
  always @* begin
    next_state = session_state_out;
    // halt and failure outrank a late success
    if (halt_in)
      next_state = STATE_UNAUTHENTICATED;
    else if (auth_fail_in)
      next_state = STATE_UNAUTHENTICATED;
    else if (auth_ok_in && session_state_out == STATE_AUTH_PENDING)
      next_state = asym_first ? STATE_AUTH_ASYMMETRIC : STATE_AUTH_SYMMETRIC;
  end
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cmd_valid_out       <= 1'b0;
      cmd_kind_out        <= KIND_NONE;
      native_cmd_out      <= 8'h00;
      lc_out              <= 16'h0000;
      write_commit_out    <= 1'b0;
      status_word_out     <= 16'h0000;
      status_valid_out    <= 1'b0;
      session_state_out   <= STATE_UNAUTHENTICATED;
      session_iface_out   <= 1'b0;
      session_key_ref_out <= 5'h00;
      sm_active_out       <= 1'b0;
      resp_pending        <= 1'b0;
      waw_active          <= 1'b0;
      resp_chunk_out      <= 16'h0000;
      owner_err           <= 1'b0;
    end else begin
      cmd_valid_out    <= 1'b0;
      write_commit_out <= 1'b0;
      status_valid_out <= 1'b0;
      owner_err        <= 1'b0;
      session_state_out <= next_state;
      if (next_state == STATE_UNAUTHENTICATED)
        session_key_ref_out <= 5'h00;
      // only the symmetric scheme remembers a key
      if (auth_ok_in && session_state_out == STATE_AUTH_PENDING && !asym_first)
        session_key_ref_out <= {1'b1, key_no_in};
      sm_active_out <= (next_state == STATE_AUTH_SYMMETRIC) || (next_state == STATE_AUTH_ASYMMETRIC);
      // the error frame replaces the dropped reply, so nothing stays owed
      if ((rd_strobe_in && !waw_active) || waw_done)
        resp_pending <= 1'b0;
      if (waw_done)
        waw_active <= 1'b0;
      if (frame_end_in && !(frame_chain_in && chainable)) begin
        if (resp_pending)
          waw_active <= 1'b1;
        resp_pending <= 1'b1;
        cmd_kind_out <= kind;
        lc_out       <= lc_acc;
        // long replies go out in host-sized pieces
        resp_chunk_out <= (le_acc == 16'h0000 || le_acc > FSD_LIMIT) ? FSD_LIMIT : le_acc;
        // buffer plus five header bytes; oversize writes stream instead
        if (total_cnt > BUF_LIMIT + 16'd5 && !big_write) begin
          status_word_out <= `AFS_SW_LEN_ERR;
          owner_err       <= 1'b1;
        end else if (kind == KIND_NONE) begin
          status_word_out <= is_std ? `AFS_SW_INS_ERR : `AFS_SW_CLA_ERR;
          owner_err       <= 1'b1;
        end else if (is_wrap && le_acc != 16'h0000) begin
          status_word_out <= `AFS_SW_LEN_ERR;
          owner_err       <= 1'b1;
        end else if (session_state_out == STATE_AUTH_PENDING && !second_part) begin
          status_word_out   <= `AFS_SW_AUTH_ERR;
          session_state_out <= STATE_UNAUTHENTICATED;
        end else begin
          cmd_valid_out  <= 1'b1;
          native_cmd_out <= is_wrap ? ins : 8'h00;
          status_word_out <= is_wrap ? `AFS_SW_WRAP_OK : `AFS_SW_OK;
          if (is_write && !big_write)
            write_commit_out <= 1'b1;
          // a new first part drops any open session at once
          if (auth_start) begin
            session_state_out   <= STATE_AUTH_PENDING;
            session_iface_out   <= frame_iface_in;
            session_key_ref_out <= 5'h00;
          end
          if ((is_std && ins == `AFS_INS_SELECT) ||
              (is_wrap && ins == `AFS_CMD_CHANGE_KEY && first_data[3:0] == session_key_ref_out[3:0]))
            session_state_out <= STATE_UNAUTHENTICATED;
        end
        status_valid_out <= 1'b1;
      end
      // closes one cycle after the error, so that
      // reply still leaves in secure messaging mode
      if (owner_err && frame_iface_in == session_iface_out)
        session_state_out <= STATE_UNAUTHENTICATED;
    end
  end
endmodule

// >>> verilog/afs_regs.vh
`ifndef AFS_REGS_VH
`define AFS_REGS_VH
// ************************************************************
// apdu header and command codes
// ************************************************************
`define AFS_CLA_STD         8'h00
`define AFS_CLA_WRAP        8'h90
`define AFS_INS_SELECT      8'hA4
`define AFS_INS_READ_BIN    8'hB0
`define AFS_INS_UPDATE_BIN  8'hD6
`define AFS_INS_GEN_AUTH    8'h86
`define AFS_CMD_SYM_FIRST   8'h71
`define AFS_CMD_SYM_NONFRST 8'h77
`define AFS_CMD_SYM_PART2   8'hAF
`define AFS_CMD_READ_DATA   8'hAD
`define AFS_CMD_WRITE_DATA  8'h8D
`define AFS_CMD_CHANGE_KEY  8'hC4
// ************************************************************
// status words
// ************************************************************
`define AFS_SW_OK           16'h9000
`define AFS_SW_WRAP_OK      16'h9100
`define AFS_SW_WRAP_MORE    16'h91AF
`define AFS_SW_AUTH_ERR     16'h91AE
`define AFS_SW_LEN_ERR      16'h6700
`define AFS_SW_INS_ERR      16'h6D00
`define AFS_SW_CLA_ERR      16'h6E00
// ************************************************************
// framing figures
// ************************************************************
`define AFS_IFS_BYTES       9'd254
`define AFS_FRAME_OVERHEAD  9'd6
`define AFS_IDLE_BYTE       8'hFF
`define AFS_WAW_LEN         3'd6
`define AFS_WAW_B0          8'hA5
`define AFS_WAW_B1          8'h82
`define AFS_WAW_B2          8'h00
`define AFS_WAW_B3          8'h00
`define AFS_WAW_B4          8'h89
`define AFS_WAW_B5          8'hE0
`endif

// >>> verilog/afs_resp_mux.v
`timescale 1ns/10ps
`include "afs_regs.vh"
// ************************************************************
// read-side byte source: idle, write-after-write error, or response
// ************************************************************
module afs_resp_mux (
  input  wire       clk_sys_in,
  input  wire       rstn_in,
  input  wire       clock_gated_in,
  input  wire       waw_active_in,
  input  wire       rd_strobe_in,
  input  wire [7:0] resp_byte_in,
  output reg  [7:0] rd_byte_out,
  output wire       waw_done_out
);
  reg  [2:0] waw_idx;
  reg  [7:0] waw_byte;
  assign waw_done_out = waw_active_in && rd_strobe_in && (waw_idx == `AFS_WAW_LEN - 3'd1);
  always @* begin
    case (waw_idx)
      3'd0:    waw_byte = `AFS_WAW_B0;
      3'd1:    waw_byte = `AFS_WAW_B1;
      3'd2:    waw_byte = `AFS_WAW_B2;
      3'd3:    waw_byte = `AFS_WAW_B3;
      3'd4:    waw_byte = `AFS_WAW_B4;
      default: waw_byte = `AFS_WAW_B5;
    endcase
  end
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      waw_idx     <= 3'd0;
      rd_byte_out <= `AFS_IDLE_BYTE;
    end else begin
      if (clock_gated_in)
        rd_byte_out <= `AFS_IDLE_BYTE;
      else if (waw_active_in)
        rd_byte_out <= waw_byte;
      else
        rd_byte_out <= resp_byte_in;
      if (!waw_active_in)
        waw_idx <= 3'd0;
      else if (rd_strobe_in)
        waw_idx <= waw_done_out ? 3'd0 : waw_idx + 3'd1;
    end
  end
endmodule
